// File: hdl/dosl_pkg.sv
// Types shared by the deceleration stall limiter
package dosl_pkg;
    // ==========================================
    // Stall mode and control method codes
    typedef enum logic [1:0] {
        DOSL_M_OFF = 2'h0,
        DOSL_M_HOLD = 2'h1,
        DOSL_M_FAST = 2'h2,
        DOSL_M_BRAKE = 2'h3
    } dosl_mode_e;
    typedef enum logic [2:0] {
        DOSL_VF = 3'h0,
        DOSL_VF_PG = 3'h1,
        DOSL_OLV1 = 3'h2,
        DOSL_FLUX = 3'h3,
        DOSL_OLV2 = 3'h4
    } dosl_meth_e;
    // ==========================================
    // Configuration held by the register file
    typedef struct packed {
        logic cls_high;
        logic [2:0] method;
        dosl_mode_e decel_stall_mode_select;
        logic [9:0] input_voltage_setting;
        logic [15:0] decel_time_setting;
    } dosl_cfg_s;
endpackage : dosl_pkg

// File: hdl/dosl_regs.svh
// Register offsets, field positions, reset values and voltage levels
`ifndef DOSL_REGS_SVH
`define DOSL_REGS_SVH
// ==========================================
// Register word indices (byte address divided by four)
`define DOSL_CTRL_OFS 4'h0
`define DOSL_VIN_OFS 4'h1
`define DOSL_DTIME_OFS 4'h2
`define DOSL_STATUS_OFS 4'h3
`define DOSL_ISTAT_OFS 4'h4
`define DOSL_IMASK_OFS 4'h5
// ==========================================
// Control fields
`define DOSL_CTRL_MODE_LSB 0
`define DOSL_CTRL_METH_LSB 2
`define DOSL_CTRL_CLS_BIT 8
// ==========================================
// Status fields
`define DOSL_ST_HOLD_BIT 0
`define DOSL_ST_LIMIT_BIT 1
`define DOSL_ST_BRAKE_BIT 2
`define DOSL_ST_EMODE_LSB 3
`define DOSL_ST_THR_LSB 16
// ==========================================
// Interrupt bits
`define DOSL_IRQ_HOLD_BIT 0
`define DOSL_IRQ_REFUSE_BIT 1
// ==========================================
// Reset values
`define DOSL_MODE_RST 2'h1
`define DOSL_METH_RST 3'h0
`define DOSL_VIN_RST 10'h190
`define DOSL_DTIME_RST 16'h03e8
// ==========================================
// Bus voltage levels in volts, and the mode 2/3 rate divisor
`define DOSL_THR_LOW_V 10'h17c
`define DOSL_THR_HI_V 10'h2f8
`define DOSL_THR_HI_LOW_V 10'h294
`define DOSL_VIN_SPLIT_V 10'h190
`define DOSL_BRK_HOLD_MARGIN_V 10'h014
`define DOSL_RATE_DIV 16'h000a
`endif

// File: hdl/dosl_step_timer.sv
// Ramp step pacing: one step pulse per interval while running
`timescale 1ns/1ns
module dosl_step_timer (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Pacing control
    input wire logic run,
    input wire logic [15:0] interval,
    // Step pulse
    output logic step
);
    logic [15:0] cnt;
    logic last;

    // A zero interval is paced as one cycle
    assign last = (cnt >= interval - 16'h0001) || (interval == 16'h0000);

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt <= 16'h0000;
            step <= 1'b0;
        end else if (!run) begin
            step <= 1'b0;
        end else if (last) begin
            cnt <= 16'h0000;
            step <= 1'b1;
        end else begin
            cnt <= cnt + 16'h0001;
            step <= 1'b0;
        end
    end
endmodule : dosl_step_timer

// File: hdl/dosl_thresh.sv
// Stall threshold selection by voltage class
`timescale 1ns/1ns
`include "dosl_regs.svh"
module dosl_thresh (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Class and input voltage
    input wire logic cls_high,
    input wire logic [9:0] input_voltage_setting,
    // Selected threshold in volts
    output logic [9:0] thr
);
    always_ff @(posedge clk) begin
        if (rst) begin
            thr <= `DOSL_THR_LOW_V;
        end else if (!cls_high) begin
            thr <= `DOSL_THR_LOW_V;
        end else if (input_voltage_setting >= `DOSL_VIN_SPLIT_V) begin
            thr <= `DOSL_THR_HI_V;
        end else begin
            thr <= `DOSL_THR_HI_LOW_V;
        end
    end
endmodule : dosl_thresh

// File: hdl/dosl_top.sv
// Deceleration overvoltage stall limiter with AXI4-Lite registers
// How it works
// - Mode 0: ramp at set decel rate, no bus-voltage limiting.
// - Mode 1: freeze ramp while bus voltage at or above threshold.
// - Mode 1: after a hold, return to the set decel time.
// - Mode 2: fastest ramp, bounded by decel time divided by ten.
// - Mode 3: limit deceleration together with the braking resistor.
// - Threshold 380 V low class; 760 V or 660 V high class.
// - Flux or open-loop vector 2: mode writes above 2 refused.
// - Flux or open-loop vector 2: stall mode ignored, no limiting.
//
// Implementation choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ns
`include "dosl_regs.svh"
module dosl_top (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // AXI4-Lite write
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read
    input wire logic arvalid,
    output logic arready,
    input wire logic [31:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // Ramp generator and bus sensing
    input wire logic decel_active,
    input wire logic [9:0] bus_volts,
    // Limiter outputs
    output logic decel_step,
    output logic limit_active,
    output logic brake_on,
    output logic irq
);
    // ==========================================
    // Register state
    dosl_pkg::dosl_cfg_s cfg;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic [31:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic hold;
    logic [9:0] thr;
    dosl_pkg::dosl_mode_e eff_mode;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    function automatic logic [3:0] reg_index(input logic [31:0] a);
        return (a[31:5] == 27'h0 && a[1:0] == 2'h0) ? {1'b0, a[4:2]} : 4'hf;
    endfunction : reg_index

    function automatic logic is_fv(input logic [2:0] m);
        return m == dosl_pkg::DOSL_FLUX || m == dosl_pkg::DOSL_OLV2;
    endfunction : is_fv

    // ==========================================
    // Write path
    logic wr_go;
    logic [31:0] ctrl_old;
    logic [31:0] ctrl_new;
    logic refuse;
    logic [31:0] dt_new;
    logic [31:0] vin_new;
    logic [31:0] mask_new;
    assign wr_go = !awready && !wready && !bvalid;
    assign ctrl_old = {23'h0, cfg.cls_high, 3'h0, cfg.method,
                       cfg.decel_stall_mode_select};
    assign ctrl_new = merge(ctrl_old, w_data, w_strb);
    assign refuse = is_fv(ctrl_new[`DOSL_CTRL_METH_LSB +: 3])
                    && ctrl_new[`DOSL_CTRL_MODE_LSB +: 2] == 2'h3;
    assign vin_new = merge({22'h0, cfg.input_voltage_setting}, w_data, w_strb);
    assign dt_new = merge({16'h0, cfg.decel_time_setting}, w_data, w_strb);
    assign mask_new = merge({30'h0, irq_mask}, w_data, w_strb);

    always_ff @(posedge clk) begin
        if (rst) begin
            awready <= 1'b1;
            wready <= 1'b1;
            bvalid <= 1'b0;
            bresp <= 2'h0;
            aw_addr <= 32'h0;
            w_data <= 32'h0;
            w_strb <= 4'h0;
        end else begin
            if (awvalid && awready) begin
                awready <= 1'b0;
                aw_addr <= awaddr;
            end
            if (wvalid && wready) begin
                wready <= 1'b0;
                w_data <= wdata;
                w_strb <= wstrb;
            end
            if (wr_go) begin
                bvalid <= 1'b1;
                bresp <= (reg_index(aw_addr) <= `DOSL_IMASK_OFS) ? 2'h0 : 2'h2;
            end
            if (bvalid && bready) begin
                bvalid <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cfg.decel_stall_mode_select <= dosl_pkg::dosl_mode_e'(`DOSL_MODE_RST);
            cfg.method <= `DOSL_METH_RST;
            cfg.cls_high <= 1'b0;
            cfg.input_voltage_setting <= `DOSL_VIN_RST;
            cfg.decel_time_setting <= `DOSL_DTIME_RST;
            irq_mask <= 2'h0;
        end else if (wr_go) begin
            unique case (reg_index(aw_addr))
                `DOSL_CTRL_OFS: begin
                    cfg.method <= ctrl_new[`DOSL_CTRL_METH_LSB +: 3];
                    cfg.cls_high <= ctrl_new[`DOSL_CTRL_CLS_BIT];
                    if (!refuse) begin
                        cfg.decel_stall_mode_select <=
                            dosl_pkg::dosl_mode_e'(ctrl_new[`DOSL_CTRL_MODE_LSB +: 2]);
                    end
                end
                `DOSL_VIN_OFS: cfg.input_voltage_setting <= vin_new[9:0];
                `DOSL_DTIME_OFS: cfg.decel_time_setting <= dt_new[15:0];
                `DOSL_IMASK_OFS: irq_mask <= mask_new[1:0];
                default: begin
                end
            endcase
        end
    end

    // ==========================================
    // Read path
    logic [31:0] rd_val;
    logic [3:0] rd_idx;
    logic rd_go;
    assign rd_idx = reg_index(araddr);
    assign rd_go = arvalid && arready;

    always_comb begin
        rd_val = 32'h0;
        unique case (rd_idx)
            `DOSL_CTRL_OFS: rd_val = ctrl_old;
            `DOSL_VIN_OFS: rd_val[9:0] = cfg.input_voltage_setting;
            `DOSL_DTIME_OFS: rd_val[15:0] = cfg.decel_time_setting;
            `DOSL_STATUS_OFS: begin
                rd_val[`DOSL_ST_HOLD_BIT] = hold;
                rd_val[`DOSL_ST_LIMIT_BIT] = limit_active;
                rd_val[`DOSL_ST_BRAKE_BIT] = brake_on;
                rd_val[`DOSL_ST_EMODE_LSB +: 2] = eff_mode;
                rd_val[`DOSL_ST_THR_LSB +: 10] = thr;
            end
            `DOSL_ISTAT_OFS: rd_val[1:0] = irq_stat;
            `DOSL_IMASK_OFS: rd_val[1:0] = irq_mask;
            default: rd_val = 32'h0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h0;
            rresp <= 2'h0;
        end else if (rd_go) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= rd_val;
            rresp <= (rd_idx <= `DOSL_IMASK_OFS) ? 2'h0 : 2'h2;
        end else if (rvalid && rready) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
        end
    end

    // ==========================================
    // Limiter core
    logic over;
    logic next_hold;
    logic next_brake;
    logic [15:0] fast_ival;
    logic [15:0] interval;
    logic [10:0] brk_level;

    assign eff_mode = is_fv(cfg.method) ? dosl_pkg::DOSL_M_OFF
                                        : cfg.decel_stall_mode_select;
    assign over = bus_volts >= thr;
    assign brk_level = {1'b0, thr} + {1'b0, `DOSL_BRK_HOLD_MARGIN_V};
    assign fast_ival = cfg.decel_time_setting / `DOSL_RATE_DIV;

    always_comb begin
        next_hold = 1'b0;
        next_brake = 1'b0;
        interval = cfg.decel_time_setting;
        unique case (eff_mode)
            dosl_pkg::DOSL_M_OFF: begin
            end
            dosl_pkg::DOSL_M_HOLD: next_hold = decel_active && over;
            dosl_pkg::DOSL_M_FAST: begin
                next_hold = decel_active && over;
                interval = fast_ival;
            end
            dosl_pkg::DOSL_M_BRAKE: begin
                next_brake = decel_active && over;
                next_hold = decel_active && ({1'b0, bus_volts} >= brk_level);
                interval = fast_ival;
            end
        endcase
    end

    dosl_thresh u_thresh (
        .clk(clk),
        .rst(rst),
        .cls_high(cfg.cls_high),
        .input_voltage_setting(cfg.input_voltage_setting),
        .thr(thr)
    );

    dosl_step_timer u_step (
        .clk(clk),
        .rst(rst),
        .run(decel_active && !next_hold),
        .interval(interval),
        .step(decel_step)
    );

    always_ff @(posedge clk) begin
        if (rst) begin
            hold <= 1'b0;
            brake_on <= 1'b0;
            limit_active <= 1'b0;
        end else begin
            hold <= next_hold;
            brake_on <= next_brake;
            limit_active <= next_hold || next_brake
                            || (decel_active && eff_mode == dosl_pkg::DOSL_M_FAST);
        end
    end

    // ==========================================
    // Interrupts: set wins over clear-on-read
    logic [1:0] irq_set;
    logic [1:0] irq_clr;
    assign irq_set = {wr_go && reg_index(aw_addr) == `DOSL_CTRL_OFS && refuse,
                      next_hold && !hold};
    assign irq_clr = (rd_go && rd_idx == `DOSL_ISTAT_OFS) ? 2'h3 : 2'h0;

    always_ff @(posedge clk) begin
        if (rst) begin
            irq_stat <= 2'h0;
            irq <= 1'b0;
        end else begin
            irq_stat <= (irq_stat & ~irq_clr) | irq_set;
            irq <= |(((irq_stat & ~irq_clr) | irq_set) & irq_mask);
        end
    end

    // ==========================================
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_off_no_hold;
        (decel_active && eff_mode == dosl_pkg::DOSL_M_OFF) |=> !hold && !brake_on;
    endproperty
    a_off_no_hold: assert property (p_off_no_hold) else $error("hold in mode 0");

    property p_hold_freezes;
        (decel_active && over && eff_mode == dosl_pkg::DOSL_M_HOLD)
            |=> hold ##0 !decel_step;
    endproperty
    a_hold_freezes: assert property (p_hold_freezes) else $error("ramp not frozen");

    property p_resume_rate;
        (eff_mode == dosl_pkg::DOSL_M_HOLD) |-> interval == cfg.decel_time_setting;
    endproperty
    a_resume_rate: assert property (p_resume_rate) else $error("mode 1 rate changed");

    property p_fast_rate;
        (eff_mode == dosl_pkg::DOSL_M_FAST) |-> interval * 16'h000a <= cfg.decel_time_setting;
    endproperty
    a_fast_rate: assert property (p_fast_rate) else $error("mode 2 rate bound");

    property p_brake;
        (decel_active && over && eff_mode == dosl_pkg::DOSL_M_BRAKE) |=> brake_on;
    endproperty
    a_brake: assert property (p_brake) else $error("brake not on");

    property p_thr;
        !cfg.cls_high ##1 !cfg.cls_high |-> thr == `DOSL_THR_LOW_V;
    endproperty
    a_thr: assert property (p_thr) else $error("low class threshold");

    property p_thr_hi;
        (cfg.cls_high && cfg.input_voltage_setting < `DOSL_VIN_SPLIT_V) ##1 $stable(cfg)
            |-> thr == `DOSL_THR_HI_LOW_V;
    endproperty
    a_thr_hi: assert property (p_thr_hi) else $error("high class threshold");

    property p_refuse;
        (wr_go && reg_index(aw_addr) == `DOSL_CTRL_OFS && refuse)
            |=> cfg.decel_stall_mode_select == $past(cfg.decel_stall_mode_select)
                ##1 irq_stat[`DOSL_IRQ_REFUSE_BIT];
    endproperty
    a_refuse: assert property (p_refuse) else $error("mode 3 accepted");

    property p_fv_ignore;
        is_fv(cfg.method) |=> !hold && !brake_on;
    endproperty
    a_fv_ignore: assert property (p_fv_ignore) else $error("limit under vector");

    property p_limit_flag;
        (hold || brake_on) |-> limit_active;
    endproperty
    a_limit_flag: assert property (p_limit_flag) else $error("limit flag low");

    c_hold: cover property (hold ##1 !hold);
    c_fast: cover property (eff_mode == dosl_pkg::DOSL_M_FAST && decel_step);
    c_brake: cover property (brake_on);
    c_irq: cover property (irq);
endmodule : dosl_top

// File: tb/dosl_drive_src.sv
// Ramp generator and bus voltage source facing the limiter
`timescale 1ns/1ns
module dosl_drive_src (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Bench commands
    input wire logic cmd_decel,
    input wire logic cmd_load,
    input wire logic [9:0] cmd_volts,
    // Limiter feedback
    input wire logic decel_step,
    input wire logic brake_on,
    // Drive side signals
    output logic decel_active,
    output logic [9:0] bus_volts
);
    // ==========================================
    // Each ramp step regenerates into the bus, the resistor drains it
    always_ff @(posedge clk) begin
        if (rst) begin
            decel_active <= 1'b0;
            bus_volts <= 10'h000;
        end else begin
            decel_active <= cmd_decel;
            if (cmd_load) begin
                bus_volts <= cmd_volts;
            end else if (decel_step && bus_volts < 10'h3f0) begin
                bus_volts <= bus_volts + 10'h002;
            end else if (brake_on && bus_volts > 10'h004) begin
                bus_volts <= bus_volts - 10'h001;
            end
        end
    end
endmodule : dosl_drive_src

// File: tb/tb_top.sv
// Self-checking bench for the deceleration stall limiter
`timescale 1ns/1ns
`include "dosl_regs.svh"
module tb_top;
    logic clk, rst, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
    logic rvalid, rready, decel_active, decel_step, limit_active, brake_on, irq;
    logic [31:0] awaddr, wdata, araddr, rdata, d, sh_mask;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r, sh_mode;
    logic [9:0] bus_volts, p_v, cmd_volts, sh_vin;
    logic cmd_decel, cmd_load, chk_en, clean, p_act, pp_act, sh_cls;
    logic [2:0] sh_meth, e;
    logic [15:0] sh_dt;
    int i, m, gap, fails, check_count, cyc;
    logic [9:0] tv [3] = '{10'h18f, 10'h190, 10'h190};
    logic tc [3] = '{1'b1, 1'b1, 1'b0};
    logic [9:0] te [3] = '{10'h294, 10'h2f8, 10'h17c};
    // ==========================================
    // Design and drive side
    dosl_top uut (.clk(clk), .rst(rst), .awvalid(awvalid), .awready(awready),
        .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
        .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
        .rdata(rdata), .rresp(rresp), .decel_active(decel_active), .bus_volts(bus_volts),
        .decel_step(decel_step), .limit_active(limit_active), .brake_on(brake_on),
        .irq(irq));
    dosl_drive_src drv (.clk(clk), .rst(rst), .cmd_decel(cmd_decel), .cmd_load(cmd_load),
        .cmd_volts(cmd_volts), .decel_step(decel_step), .brake_on(brake_on),
        .decel_active(decel_active), .bus_volts(bus_volts));
    // ==========================================
    // Reference model
    function automatic logic [9:0] thr_of();
        return sh_cls ? ((sh_vin >= 10'h190) ? 10'h2f8 : 10'h294) : 10'h17c;
    endfunction : thr_of
    function automatic logic [1:0] eff_mode();
        return (sh_meth == 3'h3 || sh_meth == 3'h4) ? 2'h0 : sh_mode;
    endfunction : eff_mode
    function automatic logic [2:0] expect_lim(input logic [9:0] v);
        logic h, b;
        h = (eff_mode() == 2'h1 || eff_mode() == 2'h2) && v >= thr_of();
        h = h || (eff_mode() == 2'h3 && v >= thr_of() + `DOSL_BRK_HOLD_MARGIN_V);
        b = eff_mode() == 2'h3 && v >= thr_of();
        return {h, b, h | b | (eff_mode() == 2'h2)};
    endfunction : expect_lim
    // ==========================================
    // Checking and closing
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : summarize
    // ==========================================
    // Bus master
    task automatic wr(input logic [31:0] a, input logic [31:0] dv, input logic [1:0] er);
        logic ad, wd;
        ad = 1'b0;
        wd = 1'b0;
        awaddr <= a;
        wdata <= dv;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(ad && wd)) begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            ad = ad | awready;
            wd = wd | wready;
        end
        do @(posedge clk); while (bvalid !== 1'b1);
        chk("bresp", 32'(bresp), 32'(er));
    endtask : wr
    task automatic rd(input logic [31:0] a, output logic [31:0] dv, output logic [1:0] rv);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk); while (rvalid !== 1'b1);
        dv = rdata;
        rv = rresp;
    endtask : rd
    task automatic set_ctrl(input logic [1:0] md, input logic [2:0] me, input logic c);
        chk_en = 1'b0;
        wr(32'h0, {23'h0, c, 3'h0, me, md}, 2'h0);
        sh_meth = me;
        sh_cls = c;
        if (!(md == 2'h3 && (me == 3'h3 || me == 3'h4))) sh_mode = md;
        repeat (3) @(posedge clk);
        chk_en = 1'b1;
    endtask : set_ctrl
    task automatic load(input logic [9:0] v);
        cmd_load <= 1'b1;
        cmd_volts <= v;
        @(posedge clk);
        cmd_load <= 1'b0;
    endtask : load
    task automatic run_bus(input int n);
        repeat (n) begin
            load(thr_of() - 10'h028 + 10'($urandom_range(80)));
            repeat (100) @(posedge clk);
        end
    endtask : run_bus
    // ==========================================
    // Clock, timeout and per-cycle comparison
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        p_act <= decel_active;
        pp_act <= p_act;
        p_v <= bus_volts;
        if (cyc == 20000) begin
            fails++;
            summarize();
        end
    end
    always @(negedge clk) begin
        e = expect_lim(p_v);
        gap = gap + 1;
        if (!chk_en || !p_act || e[2]) clean = 1'b0;
        if (chk_en && p_act) begin
            chk("limit_active", 32'(limit_active), 32'(e[0]));
            chk("brake_on", 32'(brake_on), 32'(e[1]));
            if (e[2]) chk("step_in_hold", 32'(decel_step), 32'h0);
        end
        if (chk_en && !p_act && !pp_act) chk("step_idle", 32'(decel_step), 32'h0);
        if (chk_en && sh_mask == 32'h0) chk("irq_masked", 32'(irq), 32'h0);
        if (decel_step === 1'b1) begin
            if (clean && eff_mode() >= 2'h2) chk("step_gap", 32'(gap), 32'(sh_dt / 10));
            if (clean && eff_mode() < 2'h2) chk("step_gap", 32'(gap), 32'(sh_dt));
            gap = 0;
            clean = chk_en;
        end
    end
    // ==========================================
    // Main sequence
    initial begin
        {rst, wstrb, bready, rready} = 7'h7f;
        {awvalid, wvalid, arvalid, cmd_decel, cmd_load, chk_en, clean} = 7'h00;
        {awaddr, wdata, araddr, cmd_volts, sh_mask} = '0;
        {gap, fails, check_count, cyc} = '0;
        {sh_mode, sh_meth, sh_cls, sh_vin, sh_dt} = {2'h1, 3'h0, 1'b0, 10'h190, 16'h03e8};
        void'($urandom(16027));
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(32'h18, d, r);
        chk("unmapped_rresp", 32'(r), 32'h2);
        wr(32'h18, 32'h0, 2'h2);
        rd(32'hc, d, r);
        chk("rst_thr", 32'(d[25:16]), 32'h17c);
        chk("rst_mode", 32'(d[4:3]), 32'h1);
        for (i = 0; i < 3; i++) begin
            wr(32'h4, 32'(tv[i]), 2'h0);
            sh_vin = tv[i];
            set_ctrl(2'h1, 3'h0, tc[i]);
            rd(32'hc, d, r);
            chk("threshold", 32'(d[25:16]), 32'(te[i]));
        end
        wr(32'h8, 32'h28, 2'h0);
        sh_dt = 16'h0028;
        cmd_decel <= 1'b1;
        for (m = 0; m < 4; m++) begin
            set_ctrl(2'(m), 3'h0, 1'b0);
            rd(32'hc, d, r);
            chk("eff_mode", 32'(d[4:3]), 32'(m));
            run_bus(4);
        end
        // Braking option fitted: only modes 0 and 3, and 3 for faster stops
        set_ctrl(2'h0, 3'h0, 1'b0);
        run_bus(2);
        set_ctrl(2'h3, 3'h0, 1'b0);
        run_bus(2);
        cmd_decel <= 1'b0;
        repeat (60) @(posedge clk);
        rd(32'h10, d, r);
        chk("hold_event", 32'(d[0]), 32'h1);
        rd(32'h10, d, r);
        chk("istat_clear", d, 32'h0);
        wr(32'h14, 32'h3, 2'h0);
        sh_mask = 32'h3;
        set_ctrl(2'h1, 3'h0, 1'b0);
        cmd_decel <= 1'b1;
        load(10'h190);
        repeat (4) @(posedge clk);
        chk("irq_set", 32'(irq), 32'h1);
        rd(32'h10, d, r);
        chk("istat_hold", 32'(d[0]), 32'h1);
        repeat (3) @(posedge clk);
        chk("irq_clear", 32'(irq), 32'h0);
        for (i = 3; i < 5; i++) begin
            set_ctrl(2'h1, 3'(i), 1'b0);
            set_ctrl(2'h3, 3'(i), 1'b0);
            rd(32'h0, d, r);
            chk("mode_kept", 32'(d[1:0]), 32'h1);
            chk("irq_refuse", 32'(irq), 32'h1);
            rd(32'h10, d, r);
            chk("istat_refuse", 32'(d[1]), 32'h1);
            rd(32'hc, d, r);
            chk("eff_ignored", 32'(d[4:3]), 32'h0);
            load(10'h1a4);
            repeat (120) @(posedge clk);
        end
        set_ctrl(2'h2, 3'h4, 1'b0);
        rd(32'h0, d, r);
        chk("mode_two_ok", 32'(d[1:0]), 32'h2);
        summarize();
    end
endmodule : tb_top
